// ---- design/sxl_pkg.sv ----
// constants and types for the system exception and low-power controller
package sxl_pkg;
  localparam logic [15:0] SXL_ADDR_BRK_STAT = 16'hfe00;
  localparam logic [15:0] SXL_ADDR_RST_CAUSE = 16'hfe01;
  localparam logic [15:0] SXL_ADDR_BRK_CTRL = 16'hfe03;
  // pending-status registers have no printed address; chosen here
  localparam logic [15:0] SXL_ADDR_IRQ_A = 16'hfe04;
  localparam logic [15:0] SXL_ADDR_IRQ_B = 16'hfe05;
  localparam logic [15:0] SXL_ADDR_IRQ_C = 16'hfe06;
  localparam logic [15:0] SXL_SWI_VECTOR = 16'hfffc;
  // field positions
  localparam int SXL_WBX_BIT = 1;
  localparam int SXL_BREAK_FLAG_CLEAR_ENABLE_BIT = 7;
  localparam int SXL_RC_POR = 7;
  localparam int SXL_RC_PIN = 6;
  localparam int SXL_RC_WDOG = 5;
  localparam int SXL_RC_BADOP = 4;
  localparam int SXL_RC_BADADR = 3;
  localparam int SXL_RC_MON = 2;
  localparam int SXL_RC_LV = 1;
  localparam int SXL_IRQ_SRCS = 20;
  localparam logic [7:0] SXL_RC_POR_VAL = 8'h80;
  // stop recovery in reference-clock cycles
  localparam logic [11:0] SXL_REC_LONG = 12'hfff;
  localparam logic [11:0] SXL_REC_SHORT = 12'h01f;
  typedef enum logic [1:0] {
    SXL_RUN = 2'b00,
    SXL_WAIT = 2'b01,
    SXL_STOP = 2'b10,
    SXL_RECOVER = 2'b11
  } sxl_mode_e;
endpackage : sxl_pkg

// ---- design/sxl_ctrl.sv ----
// system exception and low-power controller, single clock
module sxl_ctrl (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic por_i,
  input wire logic pin_rst_i,
  input wire logic wdog_rst_i,
  input wire logic bad_opcode_i,
  input wire logic bad_address_i,
  input wire logic brownout_i,
  input wire logic monitor_entry_i,
  input wire logic [sxl_pkg::SXL_IRQ_SRCS-1:0] irq_pending_i,
  input wire logic irq_wake_i,
  input wire logic break_req_i,
  input wire logic break_end_i,
  input wire logic wait_instr_i,
  input wire logic stop_instr_i,
  input wire logic short_stop_recovery_i,
  input wire logic watchdog_disable_i,
  input wire logic flag_clear_req_i,
  input wire logic second_step_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic sys_reset_o,
  output logic break_active_o,
  output logic vector_force_o,
  output logic [15:0] vector_addr_o,
  output logic imask_clear_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic bus_clk_en_o,
  output logic ref_clk_en_o,
  output logic watchdog_run_o,
  output logic stack_start_o,
  output logic flag_clear_ok_o
);
  import sxl_pkg::*;

  // ==========================================================
  // state
  sxl_mode_e mode_q, mode_d;
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] rec_lim_q;
  logic [7:0] cause_q, cause_d;
  logic wbx_q, wbx_d;
  logic break_flag_clear_enable_q;
  logic brk_q, brk_d;
  logic stack_q, stack_d;
  logic force_q;
  logic [7:0] rdata_d;

  // ==========================================================
  // helpers
  function automatic logic sxl_in_run(input sxl_mode_e m);
    return m == SXL_RUN;
  endfunction : sxl_in_run

  function automatic logic sxl_in_wait(input sxl_mode_e m);
    return m == SXL_WAIT;
  endfunction : sxl_in_wait

  function automatic logic sxl_in_stop(input sxl_mode_e m);
    return m == SXL_STOP;
  endfunction : sxl_in_stop

  // ==========================================================
  // decode
  wire any_rst = por_i | pin_rst_i | wdog_rst_i | bad_opcode_i |
    bad_address_i | brownout_i | monitor_entry_i;
  wire sel_bs = addr_i == SXL_ADDR_BRK_STAT;
  wire sel_rc = addr_i == SXL_ADDR_RST_CAUSE;
  wire sel_bc = addr_i == SXL_ADDR_BRK_CTRL;
  wire sel_ia = addr_i == SXL_ADDR_IRQ_A;
  wire sel_ib = addr_i == SXL_ADDR_IRQ_B;
  wire sel_ic = addr_i == SXL_ADDR_IRQ_C;
  wire [7:0] irq_a = {irq_pending_i[5:0], 2'b00};
  wire [7:0] irq_b = irq_pending_i[13:6];
  wire [7:0] irq_c = {2'b00, irq_pending_i[19:14]};
  wire [7:0] bs_val = 8'(wbx_q) << SXL_WBX_BIT;
  wire [7:0] bc_val = 8'(break_flag_clear_enable_q) << SXL_BREAK_FLAG_CLEAR_ENABLE_BIT;
  wire rec_done = cnt_q == rec_lim_q;

  // ==========================================================
  // mode sequencing
  always_comb begin
    mode_d = mode_q;
    cnt_d = cnt_q + 12'h001;
    stack_d = 1'b0;
    wbx_d = wbx_q;
    brk_d = brk_q;
    if (break_req_i) begin
      brk_d = 1'b1;
    end else if (break_end_i) begin
      brk_d = 1'b0;
    end
    // clear first so a break exit in the same cycle still sets the flag
    if (wr_i & sel_bs & ~wdata_i[SXL_WBX_BIT]) begin
      wbx_d = 1'b0;
    end
    unique case (mode_q)
      SXL_RUN: begin
        if (stop_instr_i) begin
          mode_d = SXL_STOP;
          cnt_d = 12'h000;
        end else if (wait_instr_i) begin
          mode_d = SXL_WAIT;
        end
      end
      SXL_WAIT: begin
        if (break_req_i) begin
          mode_d = SXL_RUN;
          wbx_d = 1'b1;
        end else if (irq_wake_i) begin
          mode_d = SXL_RUN;
          stack_d = 1'b1;
        end
      end
      SXL_STOP: begin
        cnt_d = 12'h000;
        if (irq_wake_i | break_req_i) begin
          mode_d = SXL_RECOVER;
        end
      end
      SXL_RECOVER: begin
        if (rec_done) begin
          mode_d = SXL_RUN;
          stack_d = 1'b1;
        end
      end
    endcase
  end

  // reset cause: read clears, new sources accumulate
  always_comb begin
    cause_d = cause_q;
    if (rd_i & sel_rc) begin
      cause_d = 8'h00;
    end
    cause_d[SXL_RC_PIN] = cause_d[SXL_RC_PIN] | pin_rst_i;
    cause_d[SXL_RC_WDOG] = cause_d[SXL_RC_WDOG] | wdog_rst_i;
    cause_d[SXL_RC_BADOP] = cause_d[SXL_RC_BADOP] | bad_opcode_i;
    cause_d[SXL_RC_BADADR] = cause_d[SXL_RC_BADADR] | bad_address_i;
    cause_d[SXL_RC_MON] = cause_d[SXL_RC_MON] | monitor_entry_i;
    cause_d[SXL_RC_LV] = cause_d[SXL_RC_LV] | brownout_i;
    if (por_i) begin
      cause_d = SXL_RC_POR_VAL;
    end
  end

  // ==========================================================
  // flops; a system reset returns the sequencer to run on the next clock edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= SXL_RUN;
      cnt_q <= 12'h000;
      stack_q <= 1'b0;
      brk_q <= 1'b0;
      wbx_q <= 1'b0;
      force_q <= 1'b0;
    end else if (any_rst) begin
      mode_q <= SXL_RUN;
      cnt_q <= 12'h000;
      stack_q <= 1'b0;
      brk_q <= 1'b0;
      wbx_q <= 1'b0;
      force_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      stack_q <= stack_d;
      brk_q <= brk_d;
      wbx_q <= wbx_d;
      force_q <= break_req_i;
    end
  end

  // cause register survives the non-power-on resets
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cause_q <= SXL_RC_POR_VAL;
    end else begin
      cause_q <= cause_d;
    end
  end

  // recovery length sampled on every cycle spent in stop
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      break_flag_clear_enable_q <= 1'b0;
      rec_lim_q <= SXL_REC_LONG;
    end else begin
      if (wr_i & sel_bc) begin
        break_flag_clear_enable_q <= wdata_i[SXL_BREAK_FLAG_CLEAR_ENABLE_BIT];
      end
      if (mode_q == SXL_STOP) begin
        rec_lim_q <= short_stop_recovery_i ? SXL_REC_SHORT : SXL_REC_LONG;
      end
    end
  end

  // ==========================================================
  // read data
  always_comb begin
    rdata_d = 8'h00;
    if (sel_bs) begin
      rdata_d = bs_val;
    end else if (sel_rc) begin
      rdata_d = cause_q;
    end else if (sel_bc) begin
      rdata_d = bc_val;
    end else if (sel_ia) begin
      rdata_d = irq_a;
    end else if (sel_ib) begin
      rdata_d = irq_b;
    end else if (sel_ic) begin
      rdata_d = irq_c;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end
  end

  // ==========================================================
  // outputs
  assign sys_reset_o = any_rst;
  assign break_active_o = brk_q;
  assign vector_force_o = force_q;
  assign vector_addr_o = SXL_SWI_VECTOR;
  // with the enable bit clear, break blocks every clear, first or second step alike
  assign flag_clear_ok_o = (~brk_q | break_flag_clear_enable_q) &
    (flag_clear_req_i | second_step_i);
  assign imask_clear_o = sxl_in_run(mode_q) &
    (wait_instr_i | stop_instr_i);
  assign cpu_clk_en_o = sxl_in_run(mode_q);
  assign periph_clk_en_o = sxl_in_run(mode_q) | sxl_in_wait(mode_q);
  assign bus_clk_en_o = ~sxl_in_stop(mode_q);
  assign ref_clk_en_o = ~sxl_in_stop(mode_q);
  assign watchdog_run_o = ~watchdog_disable_i & ~sxl_in_stop(mode_q);
  assign stack_start_o = stack_q;
endmodule : sxl_ctrl

// ---- sim/sxl_flag_model.sv ----
// peripheral status flag model on the far side of the clear gate
module sxl_flag_model (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clr_i,
  input wire logic ok_i,
  output logic flag_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // flag starts set so a blocked clear is visible
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) flag_o <= 1'b1;
    else if (clr_i && ok_i) flag_o <= 1'b0;
  end
endmodule : sxl_flag_model

// ---- sim/sxl_ctrl_assertions.sv ----
// concurrent checks on the controller ports
module sxl_ctrl_assertions
  import sxl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] rdata_o,
  input wire logic break_req_i,
  input wire logic vector_force_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic break_active_o,
  input wire logic flag_clear_ok_o,
  input wire logic flag_clear_req_i,
  input wire logic second_step_i,
  input wire logic wait_instr_i,
  input wire logic stop_instr_i,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic bus_clk_en_o,
  input wire logic ref_clk_en_o,
  input wire logic imask_clear_o,
  input wire logic sys_reset_o,
  input wire logic pin_rst_i,
  input wire logic wdog_rst_i,
  input wire logic watchdog_disable_i,
  input wire logic watchdog_run_o
);
  // ==========
  // run mode, no competing reset or break
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_go;
    cpu_clk_en_o && !sys_reset_o && !break_req_i;
  endsequence
  irq_a_low_a: assert property (
    rd_i && addr_i == SXL_ADDR_IRQ_A |=> rdata_o[1:0] == 2'h0)
    else $error("status a low bits not zero");
  irq_c_top_a: assert property (
    rd_i && addr_i == SXL_ADDR_IRQ_C |=> rdata_o[7:6] == 2'h0)
    else $error("status c top bits not zero");
  reset_first_a: assert property (
    pin_rst_i || wdog_rst_i |-> sys_reset_o)
    else $error("reset source not passed on");
  break_vec_a: assert property (
    break_req_i && !sys_reset_o |=>
      vector_force_o && vector_addr_o == SXL_SWI_VECTOR)
    else $error("break vector not forced");
  clear_free_a: assert property (
    !break_active_o && (flag_clear_req_i || second_step_i)
      |-> flag_clear_ok_o)
    else $error("clear blocked outside break");
  mask_clear_a: assert property (
    (wait_instr_i || stop_instr_i) ##0 s_go |-> imask_clear_o)
    else $error("mask not cleared");
  wait_gate_a: assert property (
    wait_instr_i && !stop_instr_i ##0 s_go |=>
      !cpu_clk_en_o && periph_clk_en_o)
    else $error("wait clock gating wrong");
  dog_runs_a: assert property (
    !watchdog_disable_i && periph_clk_en_o |-> watchdog_run_o)
    else $error("watchdog stopped");
  stop_gate_a: assert property (
    stop_instr_i ##0 s_go |=> !bus_clk_en_o && !ref_clk_en_o)
    else $error("stop clocks not gated");
endmodule : sxl_ctrl_assertions

// ---- sim/sxl_ctrl_bench.sv ----
// self-checking bench for the exception and low-power controller
module sxl_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sxl_pkg::*;
  logic sys_clk_i = '0, resetn_i = '0, irq_wake_i = '0;
  logic por_i, pin_rst_i, wdog_rst_i, bad_opcode_i, bad_address_i;
  logic brownout_i, monitor_entry_i, flag_clear_req_i, break_req_i;
  logic break_end_i, wait_instr_i, stop_instr_i, flag_q;
  logic [11:0] pv = '0;
  logic [SXL_IRQ_SRCS-1:0] irq_pending_i = '0;
  logic short_stop_recovery_i = '0, watchdog_disable_i = '0;
  logic second_step_i = '0, rd_i = '0, wr_i = '0;
  logic [15:0] addr_i = '0, vector_addr_o;
  logic [7:0] wdata_i = '0, rdata_o;
  logic sys_reset_o, break_active_o, vector_force_o, imask_clear_o;
  logic cpu_clk_en_o, periph_clk_en_o, bus_clk_en_o, ref_clk_en_o;
  logic watchdog_run_o, stack_start_o, flag_clear_ok_o;
  int miscompares = 0, n_tests = 0, n;
  // pulse inputs share one vector so a task can index them
  assign {stop_instr_i, wait_instr_i, break_end_i, break_req_i,
    flag_clear_req_i, brownout_i, monitor_entry_i, bad_address_i,
    bad_opcode_i, wdog_rst_i, pin_rst_i, por_i} = pv;
  always #12.5 sys_clk_i = ~sys_clk_i;
  sxl_ctrl dut_u (.*);
  sxl_flag_model flag_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .clr_i(flag_clear_req_i), .ok_i(flag_clear_ok_o), .flag_o(flag_q));
  // ==========
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic pulse(input int i);
    @(posedge sys_clk_i);
    pv[i] <= 1'b1;
    @(posedge sys_clk_i);
    pv[i] <= 1'b0;
    #1;
  endtask : pulse
  // bounded wait for stacking, wake raised one edge in
  task automatic wake(output int k);
    @(posedge sys_clk_i);
    irq_wake_i <= 1'b1;
    k = 0;
    while (stack_start_o !== 1'b1 && k < 5000) begin
      @(posedge sys_clk_i);
      #1 k++;
    end
    irq_wake_i <= 1'b0;
  endtask : wake
  // drive a second-step clear and sample the gate while it stands
  task automatic step2(input logic [7:0] e);
    @(posedge sys_clk_i);
    second_step_i <= 1'b1;
    #1 chk(flag_clear_ok_o, e);
    @(posedge sys_clk_i);
    second_step_i <= 1'b0;
  endtask : step2
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ==========
  // tests
  initial begin
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(SXL_ADDR_RST_CAUSE, SXL_RC_POR_VAL);
    rd(SXL_ADDR_RST_CAUSE, 8'h00);
    for (int i = 1; i <= 6; i++) begin
      pulse(i);
      rd(SXL_ADDR_RST_CAUSE, 8'h01 << (7 - i));
    end
    pulse(1);
    pulse(2);
    rd(SXL_ADDR_RST_CAUSE, 8'h60);
    pulse(0);
    rd(SXL_ADDR_RST_CAUSE, SXL_RC_POR_VAL);
    rd(16'hfe02, 8'h00);
    irq_pending_i <= 20'hfffff;
    rd(SXL_ADDR_IRQ_A, 8'hfc);
    rd(SXL_ADDR_IRQ_B, 8'hff);
    rd(SXL_ADDR_IRQ_C, 8'h3f);
    irq_pending_i <= 20'h80041;
    rd(SXL_ADDR_IRQ_A, 8'h04);
    rd(SXL_ADDR_IRQ_B, 8'h01);
    rd(SXL_ADDR_IRQ_C, 8'h20);
    pulse(8);
    chk(break_active_o, 8'h01);
    pulse(7);
    chk(flag_q, 8'h01);
    wr(SXL_ADDR_BRK_CTRL, 8'h80);
    rd(SXL_ADDR_BRK_CTRL, 8'h80);
    pulse(7);
    pulse(9);
    chk(flag_q, 8'h00);
    pulse(10);
    chk({cpu_clk_en_o, periph_clk_en_o, watchdog_run_o}, 8'h03);
    wake(n);
    chk(n <= 2, 8'h01);
    pulse(10);
    pulse(8);
    rd(SXL_ADDR_BRK_STAT, 8'h02);
    wr(SXL_ADDR_BRK_STAT, 8'h00);
    rd(SXL_ADDR_BRK_STAT, 8'h00);
    pulse(9);
    for (int s = 1; s >= 0; s--) begin
      short_stop_recovery_i <= s[0];
      pulse(11);
      chk({bus_clk_en_o, ref_clk_en_o}, 8'h00);
      wake(n);
      chk(n >= (s ? 32 : 4096) && n <= (s ? 36 : 4100), 8'h01);
    end
    wr(SXL_ADDR_BRK_CTRL, 8'h00);
    pulse(8);
    step2(8'h00);
    pulse(9);
    step2(8'h01);
    wrap_up();
  end
  initial begin
    #(25ns * 12000);
    miscompares++;
    wrap_up();
  end
endmodule : sxl_ctrl_bench
bind sxl_ctrl sxl_ctrl_assertions chk_u (.*);
